// [hw/ssc_cfg.svh]
`ifndef SSC_CFG_SVH
`define SSC_CFG_SVH
`define SSC_CLK_HZ           20000000
`define SSC_TICK_HZ          100000
`define SSC_TICK_CYC         (`SSC_CLK_HZ / `SSC_TICK_HZ)
`define SSC_PWR_DELAY_MS     70
`define SSC_PWR_DELAY_CYC    (`SSC_PWR_DELAY_MS * (`SSC_CLK_HZ / 1000))
`define SSC_SHOT_MS          20
`define SSC_SHOT_CYC         (`SSC_SHOT_MS * (`SSC_CLK_HZ / 1000))
`define SSC_MARK_GAP_US      500
`define SSC_MARK_GAP_CYC     (`SSC_MARK_GAP_US * (`SSC_CLK_HZ / 1000000))
`define SSC_SECTOR_LIMIT     128
`define SSC_INDEX_LIMIT      1024
`define SSC_REG_THRESH       1999
`define SSC_UNDER_LIMIT      2048
`define SSC_CTRL_OFS         8'h00
`define SSC_STAT_OFS         8'h04
`define SSC_COUNT_OFS        8'h08
`define SSC_CTRL_RESTART     0
`define SSC_CTRL_RST         1'b0
`define SSC_ST_DOOR          0
`define SSC_ST_FAULT         1
`define SSC_ST_HOLD          2
`define SSC_ST_SPINUP        3
`define SSC_ST_BOOST         4
`define SSC_ST_DRIVE         5
`define SSC_ST_HEADS         6
`define SSC_ST_GOOD          7
`define SSC_RESP_OKAY        2'h0
`define SSC_RESP_DECERR      2'h3
`endif

// [hw/ssc_pkg.sv]
package ssc_pkg;
    typedef enum logic [3:0] {
        STG_SECTORS  = 4'b0001,
        STG_ARMED    = 4'b0010,
        STG_INDEX    = 4'b0100,
        STG_REGULATE = 4'b1000
    } ssc_stage_t;

    typedef struct packed {
        logic [1:0]  sup1;
        logic [1:0]  sup2;
        logic        lr1;
        logic        lr2;
        logic        spv1;
        logic        spv2;
        logic        mk1;
        logic        mk2;
        logic        mk3;
        logic        us1;
        logic        us2;
        logic [20:0] pwr_cnt;
        logic        fault;
        logic        hold;
        logic        init_rst;
        logic        lr_q;
        logic        restore;
        logic        door;
        logic [7:0]  tick_cnt;
        logic        phase;
        logic        t100;
        logic        t50;
        logic [13:0] gap;
        logic        index_p;
        logic        sector_p;
        logic        idx_o;
        logic        sec_o;
        logic        pse_o;
        ssc_stage_t  stage;
        logic [11:0] cnt;
        logic [11:0] cnt_latch;
        logic        boost_request_flop;
        logic        drive_current_flop;
        logic        rev_mark_capture_flop;
        logic        rev_mark_sync_flop;
        logic        pending;
        logic        heads_down_flop;
        logic        loaded_once;
        logic        speed_good_flop;
        logic [18:0] shot_cnt;
        logic        kick;
        logic        ctrl_restart;
        logic        awready;
        logic        wready;
        logic        aw_have;
        logic        w_have;
        logic [7:0]  awaddr;
        logic        wbit;
        logic        wstrb0;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        arready;
        logic        rvalid;
        logic [1:0]  rresp;
        logic [31:0] rdata;
    } ssc_state_t;
endpackage

// [hw/ssc_spindle_ctrl.sv]
// Contract
// RULE1: Either supply low raises supply fault and write inhibit.
// RULE2: Drive reset holds until the fixed delay after fault ends.
// RULE3: During the delay assert servo disable, servo hold, initial reset; initial reset is only a one-cycle pulse as hold rises.
// RULE4: Initial reset returns cylinder logic to cylinder zero.
// RULE5: Any supply drop restarts the whole power reset sequence.
// RULE6: Low load/run line causes load/run reset and a head restore.
// RULE7: Door lock stays engaged while spindle voltage is sensed.
// RULE8: Count sector pulses; past 128 the next pulse sets boost request.
// RULE9: Next sector pulse sets the drive current flop.
// RULE10: Count index pulses to 1024, end spin-up, keep the count.
// RULE11: Capture flop held clear in spin-up, set by later index.
// RULE12: At index time boost request follows count above 1999.
// RULE13: Next sector pulse copies boost request into drive current.
// RULE14: Index synchronised through capture, sync, clear, sync clear.
// RULE15: First overspeed drop toggles heads down and fires the one-shot.
// RULE16: Speed good sets when count exceeds 1999 with heads down.
// RULE17: Count reaching 2048 unloads heads and clears speed good.
// RULE18: Speed good lights ready and gates interface lines with select.
// RULE19: Index separated from sector marks, each on its own line.
// RULE20: Pseudo sector marks are every second 100 KHz pulse.
// RULE21: Load/run reset clears the spin-up state, sets spin-up phase.
//
// The register addresses and register access over AXI4-Lite were left to the implementer.
`timescale 1ns/10ps
`include "ssc_cfg.svh"

module ssc_spindle_ctrl
    import ssc_pkg::*;
#(
    parameter int PWR_DELAY_CYC = `SSC_PWR_DELAY_CYC,
    parameter int SHOT_CYC      = `SSC_SHOT_CYC,
    parameter int MARK_GAP_CYC  = `SSC_MARK_GAP_CYC
) (
    input  wire logic        ref_clk_in,
    input  wire logic        sys_rst_in,
    input  wire logic [1:0]  supply_low_in,
    input  wire logic        load_run_n_in,
    input  wire logic        spindle_volt_in,
    input  wire logic        mark_pulse_in,
    input  wire logic        unit_select_in,
    input  wire logic [7:0]  s_axi_awaddr_in,
    input  wire logic        s_axi_awvalid_in,
    output logic             s_axi_awready_out,
    input  wire logic [31:0] s_axi_wdata_in,
    input  wire logic [3:0]  s_axi_wstrb_in,
    input  wire logic        s_axi_wvalid_in,
    output logic             s_axi_wready_out,
    output logic [1:0]       s_axi_bresp_out,
    output logic             s_axi_bvalid_out,
    input  wire logic        s_axi_bready_in,
    input  wire logic [7:0]  s_axi_araddr_in,
    input  wire logic        s_axi_arvalid_in,
    output logic             s_axi_arready_out,
    output logic [31:0]      s_axi_rdata_out,
    output logic [1:0]       s_axi_rresp_out,
    output logic             s_axi_rvalid_out,
    input  wire logic        s_axi_rready_in,
    output logic             supply_fault_out,
    output logic             write_inhibit_out,
    output logic             drive_reset_out,
    output logic             servo_disable_out,
    output logic             servo_hold_out,
    output logic             initial_reset_out,
    output logic             restore_out,
    output logic             door_lock_out,
    output logic             drive_current_out,
    output logic             heads_down_out,
    output logic             head_load_kick_out,
    output logic             ready_lamp_out,
    output logic             index_mark_out,
    output logic             sector_mark_out,
    output logic             pseudo_sector_out
);

    ssc_state_t  s;
    ssc_state_t  n;
    logic        lrr;
    logic        gate;
    logic        strobe;
    logic        over;
    logic        edge_seen;
    logic [31:0] stat;

    // Load/run reset: switch line, power hold or software restart
    assign lrr       = !s.lr2 || s.hold || s.ctrl_restart; // [RULE6] [RULE5]
    assign gate      = s.speed_good_flop && s.us2;
    assign strobe    = s.t50 && s.rev_mark_capture_flop
                       && !s.rev_mark_sync_flop;
    assign over      = s.cnt > 12'(`SSC_REG_THRESH);
    assign edge_seen = s.mk2 && !s.mk3;

    always_comb begin
        n = s;
        stat = '0;
        n.sup1 = supply_low_in;
        n.sup2 = s.sup1;
        n.lr1  = load_run_n_in;
        n.lr2  = s.lr1;
        n.spv1 = spindle_volt_in;
        n.spv2 = s.spv1;
        n.mk1  = mark_pulse_in;
        n.mk2  = s.mk1;
        n.mk3  = s.mk2;
        n.us1  = unit_select_in;
        n.us2  = s.us1;

        // Power monitor and start-up delay
        if (|s.sup2) begin
            n.fault   = 1'b1;                                // [RULE1]
            n.pwr_cnt = 21'(PWR_DELAY_CYC);                  // [RULE5]
        end else begin
            n.fault = 1'b0;
            if (s.pwr_cnt != '0)
                n.pwr_cnt = s.pwr_cnt - 21'd1;               // [RULE2]
        end
        n.hold     = n.fault || (n.pwr_cnt != '0);           // [RULE3]
        n.init_rst = n.hold && !s.hold;                      // [RULE4]
        n.lr_q     = lrr;
        n.restore  = lrr && !s.lr_q;                         // [RULE6]
        n.door     = s.spv2;                                 // [RULE7]

        // 100 KHz tick, alternate ticks form the 50 KHz clock
        if (s.tick_cnt == 8'(`SSC_TICK_CYC - 1)) begin
            n.tick_cnt = '0;
            n.t100     = 1'b1;
            n.phase    = !s.phase;
            n.t50      = s.phase;                            // [RULE20]
        end else begin
            n.tick_cnt = s.tick_cnt + 8'd1;
            n.t100     = 1'b0;
            n.t50      = 1'b0;
        end

        // A mark close behind the previous one is the index slot
        n.index_p  = 1'b0;
        n.sector_p = 1'b0;
        if (s.gap != '1)
            n.gap = s.gap + 14'd1;
        if (edge_seen) begin
            if (s.gap < 14'(MARK_GAP_CYC))
                n.index_p = 1'b1;                            // [RULE19]
            else
                n.sector_p = 1'b1;                           // [RULE19]
            n.gap = '0;
        end
        n.idx_o = s.index_p && gate;                         // [RULE18]
        n.sec_o = s.sector_p && gate;                        // [RULE18]
        n.pse_o = s.t50 && gate;                             // [RULE20]

        if (s.shot_cnt != '0)
            n.shot_cnt = s.shot_cnt - 19'd1;

        if (lrr) begin
            n.stage                 = STG_SECTORS;           // [RULE21]
            n.cnt                   = '0;
            n.boost_request_flop    = 1'b0;
            n.drive_current_flop    = 1'b0;
            n.rev_mark_capture_flop = 1'b0;
            n.rev_mark_sync_flop    = 1'b0;
            n.pending               = 1'b0;
            n.heads_down_flop       = 1'b0;
            n.loaded_once           = 1'b0;
            n.speed_good_flop       = 1'b0;
        end else begin
            unique case (s.stage)
                STG_SECTORS: begin
                    if (s.sector_p) begin
                        if (s.cnt == 12'(`SSC_SECTOR_LIMIT)) begin
                            n.boost_request_flop = 1'b1;     // [RULE8]
                            n.stage = STG_ARMED;
                        end else begin
                            n.cnt = s.cnt + 12'd1;           // [RULE8]
                        end
                    end
                end
                STG_ARMED: begin
                    if (s.sector_p) begin
                        n.drive_current_flop = 1'b1;         // [RULE9]
                        n.cnt   = '0;
                        n.stage = STG_INDEX;
                    end
                end
                STG_INDEX: begin
                    if (s.index_p) begin
                        n.cnt = s.cnt + 12'd1;               // [RULE10]
                        if (s.cnt == 12'(`SSC_INDEX_LIMIT - 1))
                            n.stage = STG_REGULATE;          // [RULE10]
                    end
                end
                STG_REGULATE: begin
                    if (s.t50 && s.cnt != '1)
                        n.cnt = s.cnt + 12'd1;               // [RULE12]
                    if (strobe) begin
                        n.rev_mark_sync_flop = 1'b1;         // [RULE14]
                        n.boost_request_flop = over;         // [RULE12]
                        n.pending   = 1'b1;
                        n.cnt_latch = s.cnt;
                        if (s.boost_request_flop && !over
                            && !s.loaded_once) begin
                            n.heads_down_flop = !s.heads_down_flop; // [RULE15]
                            n.loaded_once     = 1'b1;
                            n.shot_cnt        = 19'(SHOT_CYC); // [RULE15]
                        end
                        if (over && s.heads_down_flop)
                            n.speed_good_flop = 1'b1;        // [RULE16]
                    end
                    if (s.t100 && s.rev_mark_sync_flop
                        && s.rev_mark_capture_flop) begin
                        n.rev_mark_capture_flop = 1'b0;      // [RULE14]
                        n.cnt = '0;                          // [RULE14]
                    end
                    if (s.t50 && s.rev_mark_sync_flop
                        && !s.rev_mark_capture_flop)
                        n.rev_mark_sync_flop = 1'b0;         // [RULE14]
                    // Index set after the clear so a coincident mark wins
                    if (s.index_p)
                        n.rev_mark_capture_flop = 1'b1;      // [RULE11]
                    if (s.pending && s.sector_p) begin
                        n.drive_current_flop = s.boost_request_flop; // [RULE13]
                        n.pending = 1'b0;
                    end
                    if (s.cnt >= 12'(`SSC_UNDER_LIMIT)) begin
                        n.heads_down_flop = 1'b0;            // [RULE17]
                        n.speed_good_flop = 1'b0;            // [RULE17]
                    end
                end
            endcase
        end
        n.kick = n.shot_cnt != '0;

        // Register slave
        if (s_axi_awvalid_in && s.awready) begin
            n.aw_have = 1'b1;
            n.awaddr  = s_axi_awaddr_in;
        end
        if (s_axi_wvalid_in && s.wready) begin
            n.w_have = 1'b1;
            n.wbit   = s_axi_wdata_in[`SSC_CTRL_RESTART];
            n.wstrb0 = s_axi_wstrb_in[0];
        end
        if (s.bvalid && s_axi_bready_in)
            n.bvalid = 1'b0;
        if (s.aw_have && s.w_have && !s.bvalid) begin
            n.aw_have = 1'b0;
            n.w_have  = 1'b0;
            n.bvalid  = 1'b1;
            n.bresp   = `SSC_RESP_OKAY;
            unique case ({s.awaddr[7:2], 2'b00})
                `SSC_CTRL_OFS: begin
                    if (s.wstrb0)
                        n.ctrl_restart = s.wbit;
                end
                `SSC_STAT_OFS, `SSC_COUNT_OFS: begin
                end
                default: n.bresp = `SSC_RESP_DECERR;
            endcase
        end
        stat[`SSC_ST_DOOR]   = s.door;
        stat[`SSC_ST_FAULT]  = s.fault;
        stat[`SSC_ST_HOLD]   = s.hold;
        stat[`SSC_ST_SPINUP] = s.stage != STG_REGULATE;
        stat[`SSC_ST_BOOST]  = s.boost_request_flop;
        stat[`SSC_ST_DRIVE]  = s.drive_current_flop;
        stat[`SSC_ST_HEADS]  = s.heads_down_flop;
        stat[`SSC_ST_GOOD]   = s.speed_good_flop;
        if (s.rvalid && s_axi_rready_in)
            n.rvalid = 1'b0;
        if (s_axi_arvalid_in && s.arready) begin
            n.rvalid = 1'b1;
            n.rresp  = `SSC_RESP_OKAY;
            n.rdata  = '0;
            unique case ({s_axi_araddr_in[7:2], 2'b00})
                `SSC_CTRL_OFS:
                    n.rdata[`SSC_CTRL_RESTART] = s.ctrl_restart;
                `SSC_STAT_OFS:  n.rdata = stat;
                `SSC_COUNT_OFS: n.rdata = {20'h0, s.cnt_latch};
                default:        n.rresp = `SSC_RESP_DECERR;
            endcase
        end
        n.awready = !n.aw_have && !n.bvalid;
        n.wready  = !n.w_have && !n.bvalid;
        n.arready = !n.rvalid;

        if (sys_rst_in) begin
            n              = '0;
            n.gap          = '1;
            n.lr1          = 1'b1;
            n.lr2          = 1'b1;
            n.stage        = STG_SECTORS;
            n.ctrl_restart = `SSC_CTRL_RST;
        end
    end

    always_ff @(posedge ref_clk_in) begin
        s <= n;
    end

    assign s_axi_awready_out  = s.awready;
    assign s_axi_wready_out   = s.wready;
    assign s_axi_bresp_out    = s.bresp;
    assign s_axi_bvalid_out   = s.bvalid;
    assign s_axi_arready_out  = s.arready;
    assign s_axi_rdata_out    = s.rdata;
    assign s_axi_rresp_out    = s.rresp;
    assign s_axi_rvalid_out   = s.rvalid;
    assign supply_fault_out   = s.fault;
    assign write_inhibit_out  = s.fault;
    assign drive_reset_out    = s.hold;
    assign servo_disable_out  = s.hold;
    assign servo_hold_out     = s.hold;
    assign initial_reset_out  = s.init_rst;
    assign restore_out        = s.restore;
    assign door_lock_out      = s.door;
    assign drive_current_out  = s.drive_current_flop;
    assign heads_down_out     = s.heads_down_flop;
    assign head_load_kick_out = s.kick;
    assign ready_lamp_out     = s.speed_good_flop;
    assign index_mark_out     = s.idx_o;
    assign sector_mark_out    = s.sec_o;
    assign pseudo_sector_out  = s.pse_o;

    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (sys_rst_in);

    property p_fault_raise;
        (|s.sup2) |=> s.fault && s.hold;
    endproperty
    a_fault_raise: assert property (p_fault_raise) // [RULE1]
        else $error("supply low did not raise fault");

    property p_delay_start;
        $fell(s.fault) |-> s.hold
            && s.pwr_cnt == 21'(PWR_DELAY_CYC - 1);
    endproperty
    a_delay_start: assert property (p_delay_start) // [RULE2]
        else $error("reset delay not started at full length");

    property p_init_pulse;
        $rose(s.hold) |-> s.init_rst ##1 !s.init_rst;
    endproperty
    a_init_pulse: assert property (p_init_pulse) // [RULE3]
        else $error("initial reset not a single pulse");

    property p_door;
        s.spv2 |=> s.door;
    endproperty
    a_door: assert property (p_door) // [RULE7]
        else $error("door unlocked with spindle voltage");

    property p_sector_arm;
        (!lrr && s.stage == STG_SECTORS && s.sector_p
            && s.cnt == 12'(`SSC_SECTOR_LIMIT))
        |=> s.boost_request_flop && s.stage == STG_ARMED;
    endproperty
    a_sector_arm: assert property (p_sector_arm) // [RULE8]
        else $error("boost request not set after sector count");

    property p_capture_clear;
        s.stage != STG_REGULATE |-> !s.rev_mark_capture_flop;
    endproperty
    a_capture_clear: assert property (p_capture_clear) // [RULE11]
        else $error("capture flop set during spin-up");

    property p_decide;
        (!lrr && s.stage == STG_REGULATE && strobe)
        |=> s.boost_request_flop == $past(over) && s.rev_mark_sync_flop;
    endproperty
    a_decide: assert property (p_decide) // [RULE12]
        else $error("index decision wrong");

    property p_follow;
        (!lrr && s.stage == STG_REGULATE && s.pending && s.sector_p)
        |=> s.drive_current_flop == $past(s.boost_request_flop);
    endproperty
    a_follow: assert property (p_follow) // [RULE13]
        else $error("drive current did not follow boost request");

    property p_under;
        (!lrr && s.stage == STG_REGULATE
            && s.cnt >= 12'(`SSC_UNDER_LIMIT))
        |=> !s.heads_down_flop && !s.speed_good_flop;
    endproperty
    a_under: assert property (p_under) // [RULE17]
        else $error("underspeed did not unload heads");

    property p_good;
        (!lrr && s.stage == STG_REGULATE && strobe && over
            && s.heads_down_flop && !s.cnt[11]) |=> s.speed_good_flop;
    endproperty
    a_good: assert property (p_good) // [RULE16]
        else $error("speed good not set above threshold");

    c_regulate: cover property ($rose(s.stage == STG_REGULATE));
    c_heads:    cover property ($rose(s.heads_down_flop));
    c_good:     cover property ($rose(s.speed_good_flop));
    c_write:    cover property (s.bvalid && s_axi_bready_in);

endmodule

// [test/ssc_mark_model.sv]
`timescale 1ns/10ps
// Slotted hub seen through the mark transducer: mode 0 idle,
// 1 sector slots only, 2 sector slot plus a close index slot.
module ssc_mark_model (
    input  wire logic       clk_in,
    input  wire logic       rst_in,
    input  wire logic [1:0] mode_in,
    output logic            mark_out
);
    logic [7:0] slot_cnt;
    always_ff @(posedge clk_in) begin
        if (rst_in || mode_in == 2'h0) begin
            slot_cnt <= 8'h00;
            mark_out <= 1'b0;
        end else begin
            slot_cnt <= (slot_cnt == 8'h31) ? 8'h00 : slot_cnt + 8'h01;
            // Index slot 12 cycles after a sector, gap set at 20
            mark_out <= (slot_cnt < 8'h02) || (mode_in == 2'h2 &&
                        slot_cnt >= 8'h0c && slot_cnt < 8'h0e);
        end
    end
endmodule

// [test/spindle_startup_speed_control_tb_top.sv]
`timescale 1ns/10ps
`include "ssc_cfg.svh"
module spindle_startup_speed_control_tb_top;
    localparam int P = 200;
    localparam int SH = 50;
    localparam logic [7:0] ST = `SSC_STAT_OFS;
    localparam logic [7:0] CT = `SSC_CTRL_OFS;
    logic        clk = 0, rst = 1, lr_n = 1, sv = 0, usel = 1, mark;
    logic [1:0]  sl = 2'h1, mode = 2'h0, br, rr;
    logic [7:0]  awa = 8'h00, ara = 8'h00;
    logic [31:0] wd = 32'h0, rdat;
    logic        awv = 0, wv = 0, bre = 0, arv = 0, rre = 0, mark_q = 0;
    logic        awr, wr_r, bv, arr, rv, flt, wi, drst, sdis, shold, irst;
    logic        rsto, door, cur, hd, kick, lamp, im, sm, ps;
    int          n_fail = 0, cmp_count = 0, n_rst = 0, n_ini = 0;
    int          n_leak = 0, marks = 0;
    always #25 clk = ~clk;
    always @(posedge clk) begin
        mark_q <= mark;
        if (mark && !mark_q) marks <= marks + 1;
        if (rsto) n_rst <= n_rst + 1;
        if (irst) n_ini <= n_ini + 1;
        if (!lamp && (im || sm || ps)) n_leak <= n_leak + 1;
    end
    ssc_mark_model u_marks (.clk_in(clk), .rst_in(rst), .mode_in(mode),
        .mark_out(mark));
    ssc_spindle_ctrl #(.PWR_DELAY_CYC(P), .SHOT_CYC(SH),
        .MARK_GAP_CYC(20)) dut (.ref_clk_in(clk), .sys_rst_in(rst),
        .supply_low_in(sl), .load_run_n_in(lr_n), .spindle_volt_in(sv),
        .mark_pulse_in(mark), .unit_select_in(usel),
        .s_axi_awaddr_in(awa), .s_axi_awvalid_in(awv),
        .s_axi_awready_out(awr), .s_axi_wdata_in(wd),
        .s_axi_wstrb_in(4'hf), .s_axi_wvalid_in(wv),
        .s_axi_wready_out(wr_r), .s_axi_bresp_out(br),
        .s_axi_bvalid_out(bv), .s_axi_bready_in(bre),
        .s_axi_araddr_in(ara), .s_axi_arvalid_in(arv),
        .s_axi_arready_out(arr), .s_axi_rdata_out(rdat),
        .s_axi_rresp_out(rr), .s_axi_rvalid_out(rv),
        .s_axi_rready_in(rre), .supply_fault_out(flt),
        .write_inhibit_out(wi), .drive_reset_out(drst),
        .servo_disable_out(sdis), .servo_hold_out(shold),
        .initial_reset_out(irst), .restore_out(rsto),
        .door_lock_out(door), .drive_current_out(cur),
        .heads_down_out(hd), .head_load_kick_out(kick),
        .ready_lamp_out(lamp), .index_mark_out(im),
        .sector_mark_out(sm), .pseudo_sector_out(ps));
    task automatic test_done;
        $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        cmp_count++;
        if (g !== e) begin
            n_fail++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task automatic hang;
        chk(32'h0, 32'h1);
        test_done();
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d,
                      output logic [1:0] r);
        int i;
        @(posedge clk);
        awa <= a;
        wd <= d;
        awv <= 1;
        wv <= 1;
        bre <= 1;
        for (i = 0; i < 50; i++) begin
            @(posedge clk);
            if (awr) awv <= 0;
            if (wr_r) wv <= 0;
            if (bv) break;
        end
        if (i == 50) hang();
        r = br;
        bre <= 0;
    endtask
    task automatic rd_reg(input logic [7:0] a, output logic [31:0] d,
                          output logic [1:0] r);
        int i;
        @(posedge clk);
        ara <= a;
        arv <= 1;
        rre <= 1;
        for (i = 0; i < 50; i++) begin
            @(posedge clk);
            if (arr) arv <= 0;
            if (rv) break;
        end
        if (i == 50) hang();
        d = rdat;
        r = rr;
        rre <= 0;
    endtask
    task automatic rchk(input logic [7:0] a, input logic [31:0] m,
                        input logic [31:0] e);
        logic [31:0] d;
        logic [1:0]  r;
        rd_reg(a, d, r);
        chk(d & m, e);
    endtask
    task automatic wait_marks(input int n);
        int i;
        for (i = 0; i < 60000 && marks < n; i++) @(posedge clk);
        if (i == 60000) hang();
    endtask
    task automatic wait_up(output int i);
        for (i = 0; i < P + 50 && drst; i++) @(posedge clk);
        if (i == P + 50) hang();
    endtask
    task automatic s_power;
        int i;
        cyc(6);
        chk({flt, wi, drst, sdis, shold}, 5'h1f);
        sl <= 2'h0;
        wait_up(i);
        chk(i >= P && i <= P + 8, 1);
        chk({flt, wi, sdis, shold}, 0);
    endtask
    task automatic s_bus;
        logic [31:0] d;
        logic [1:0]  r;
        int          b;
        rd_reg(8'h0c, d, r);
        chk(r, `SSC_RESP_DECERR);
        wr(8'h10, 32'h1, r);
        chk(r, `SSC_RESP_DECERR);
        wr(ST, 32'hff, r);
        chk(r, `SSC_RESP_OKAY);
        b = n_rst;
        wr(CT, 32'h1, r);
        rchk(CT, 32'h1, 32'h1);
        chk(n_rst - b, 1);
        rchk(ST, 32'h78, 32'h08);
        wr(CT, 32'h0, r);
    endtask
    task automatic s_spin;
        int b, i;
        mode <= 2'h1;
        b = marks;
        wait_marks(b + 128);
        cyc(8);
        rchk(ST, 32'h30, 32'h00);
        wait_marks(b + 129);
        cyc(8);
        rchk(ST, 32'h38, 32'h18);
        wait_marks(b + 130);
        cyc(8);
        rchk(ST, 32'h38, 32'h38);
        chk(cur, 1);
        wait_marks(b + 131);
        mode <= 2'h2;
        b = marks;
        wait_marks(b + 2045);
        cyc(8);
        rchk(ST, 32'h08, 32'h08);
        wait_marks(b + 2047);
        cyc(8);
        rchk(ST, 32'h08, 32'h00);
        for (i = 0; i < 1000 && !kick; i++) @(posedge clk);
        if (i == 1000) hang();
        for (i = 0; i < SH + 10 && kick; i++) @(posedge clk);
        chk(i, SH);
        cyc(60);
        chk({hd, cur}, 2'h2);
        rchk(ST, 32'h70, 32'h40);
        rchk(`SSC_COUNT_OFS, 32'hffe, 32'h400);
    endtask
    task automatic s_drop;
        int b, i;
        b = n_ini;
        sv <= 1;
        sl <= 2'h2;
        cyc(8);
        chk({flt, wi, drst, hd, door}, 5'h1d);
        sl <= 2'h0;
        sv <= 0;
        wait_up(i);
        chk(n_ini - b, 1);
        chk(door, 0);
        rchk(ST, 32'h78, 32'h08);
    endtask
    task automatic s_lr;
        int b;
        b = n_rst;
        lr_n <= 0;
        cyc(8);
        chk(n_rst - b, 1);
        rchk(ST, 32'h78, 32'h08);
        lr_n <= 1;
    endtask
    initial begin
        repeat (3) @(posedge clk);
        rst <= 0;
        s_power();
        s_bus();
        s_spin();
        s_drop();
        s_lr();
        chk(n_leak, 0);
        chk(lamp, 0);
        test_done();
    end
endmodule
